// ==== hw/mi_indexer.sv ====
/*
 microstep indexer: step/direction pins to signed winding targets,
 with an ahb-lite slave for sleep control and position status.
 assumes the tri-level comparators, the analog undervoltage flag and
 the bridge stage sit outside; all pin inputs are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mi_map.svh"

module mi_indexer (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // step/direction pins
   input wire logic i_step,
   input wire logic i_travel_sense,
   input wire logic [1:0] i_step_cfg_lo,
   input wire logic [1:0] i_step_cfg_hi,
   input wire logic i_output_disable_n,
   // analog undervoltage flag
   input wire logic i_uvlo,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // winding targets and bridge enable
   output mi_pkg::mi_wind_type o_wind_a,
   output mi_pkg::mi_wind_type o_wind_b,
   output logic o_bridge_en,
   output logic [6:0] o_pos_idx
);

   //------------------------------------------------------------
   // quarter-wave table
   //------------------------------------------------------------

   // percent of full scale at k/32 of a quarter turn
   function automatic logic [6:0] mi_sin(input logic [5:0] k);
      logic [6:0] v;
      v = 7'h00;
      case (k)
         6'h00: v = 7'h00;
         6'h01: v = 7'h05;
         6'h02: v = 7'h0A;
         6'h03: v = 7'h0F;
         6'h04: v = 7'h14;
         6'h05: v = 7'h18;
         6'h06: v = 7'h1D;
         6'h07: v = 7'h22;
         6'h08: v = 7'h26;
         6'h09: v = 7'h2B;
         6'h0A: v = 7'h2F;
         6'h0B: v = 7'h33;
         6'h0C: v = 7'h38;
         6'h0D: v = 7'h3C;
         6'h0E: v = 7'h3F;
         6'h0F: v = 7'h43;
         6'h10: v = 7'h47;
         6'h11: v = 7'h4A;
         6'h12: v = 7'h4D;
         6'h13: v = 7'h50;
         6'h14: v = 7'h53;
         6'h15: v = 7'h56;
         6'h16: v = 7'h58;
         6'h17: v = 7'h5A;
         6'h18: v = 7'h5C;
         6'h19: v = 7'h5E;
         6'h1A: v = 7'h60;
         6'h1B: v = 7'h61;
         6'h1C: v = 7'h62;
         6'h1D: v = 7'h63;
         default: v = 7'h64;
      endcase
      return v;
   endfunction

   //------------------------------------------------------------
   // format helpers
   //------------------------------------------------------------

   // index distance between valid entries of a format
   function automatic logic [6:0] mi_fmt_step(input mi_pkg::mi_fmt_type f);
      logic [6:0] s;
      s = `MI_STEP_32ND;
      case (f)
         mi_pkg::FMT_FULL: s = `MI_STEP_FULL;
         mi_pkg::FMT_HALF: s = `MI_STEP_HALF;
         mi_pkg::FMT_QTR: s = `MI_STEP_QTR;
         mi_pkg::FMT_8TH: s = `MI_STEP_8TH;
         mi_pkg::FMT_16TH: s = `MI_STEP_16TH;
         default: s = `MI_STEP_32ND;
      endcase
      return s;
   endfunction

   //------------------------------------------------------------
   // state and decode signals
   //------------------------------------------------------------

   mi_pkg::mi_state_type st_reg;
   mi_pkg::mi_state_type st_next;
   mi_pkg::mi_fmt_type fmt;
   logic dual;
   logic rise;
   logic fall;
   logic adv;
   logic [6:0] stp;
   logic [6:0] ofs;
   logic [6:0] base;
   logic [6:0] algn;
   logic [6:0] nidx;
   logic [4:0] rem;
   logic [6:0] s_r;
   logic [6:0] s_c;
   logic addr_ph;
   logic [6:0] idx_new;

   //------------------------------------------------------------
   // step format decode
   //------------------------------------------------------------

   // tri-level pair to format and edge mode
   always_comb begin
      fmt = mi_pkg::FMT_FULL;
      dual = 1'b0;
      case (st_reg.hi_s2)
         `MI_TRI_Z: begin
            case (st_reg.lo_s2)
               `MI_TRI_Z: begin
                  fmt = mi_pkg::FMT_8TH;
                  dual = 1'b1;
               end
               `MI_TRI_HIGH: begin
                  fmt = mi_pkg::FMT_16TH;
               end
               default: begin
                  fmt = mi_pkg::FMT_8TH;
               end
            endcase
         end
         `MI_TRI_HIGH: begin
            case (st_reg.lo_s2)
               `MI_TRI_Z: begin
                  fmt = mi_pkg::FMT_32ND;
               end
               `MI_TRI_HIGH: begin
                  fmt = mi_pkg::FMT_32ND;
                  dual = 1'b1;
               end
               default: begin
                  fmt = mi_pkg::FMT_16TH;
                  dual = 1'b1;
               end
            endcase
         end
         default: begin
            case (st_reg.lo_s2)
               `MI_TRI_Z: fmt = mi_pkg::FMT_HALF;
               `MI_TRI_HIGH: fmt = mi_pkg::FMT_QTR;
               default: fmt = mi_pkg::FMT_FULL;
            endcase
         end
      endcase
   end

   //------------------------------------------------------------
   // step edge and next position
   //------------------------------------------------------------

   // edges from successive synchronised samples
   assign rise = st_reg.step_s2 & ~st_reg.step_prev;
   assign fall = ~st_reg.step_s2 & st_reg.step_prev;
   assign adv = rise | (fall & dual);

   // full step sits on the odd 45 degree family
   assign stp = mi_fmt_step(fmt);
   assign ofs = (fmt == mi_pkg::FMT_FULL) ? `MI_FULL_OFS : 7'h00;
   assign base = st_reg.idx - ofs;
   assign algn = base & ~(stp - 7'h01);

   // move to the next entry valid for the present format
   always_comb begin
      if (st_reg.dir_s2) begin
         nidx = algn + stp + ofs;
      end else if (base == algn) begin
         nidx = algn - stp + ofs;
      end else begin
         nidx = algn + ofs;
      end
   end

   // position after this cycle: held home in sleep or lockout; kept apart from
   // the state copy so the table lookup does not loop back into it
   always_comb begin
      if (st_reg.uvlo_s2 | st_reg.sleep) begin
         idx_new = `MI_HOME_IDX;
      end else if (adv) begin
         idx_new = nidx;
      end else begin
         idx_new = st_reg.idx;
      end
   end

   //------------------------------------------------------------
   // quadrant lookup of the winding targets
   //------------------------------------------------------------

   assign rem = idx_new[4:0];
   assign s_r = mi_sin({1'b0, rem});
   assign s_c = mi_sin(`MI_QUARTER - {1'b0, rem});

   //------------------------------------------------------------
   // bus address phase
   //------------------------------------------------------------

   assign addr_ph = i_hsel & i_hready & i_htrans[1];

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------

   always_comb begin
      st_next = st_reg;
      // two-stage synchronisers
      st_next.step_s1 = i_step;
      st_next.step_s2 = st_reg.step_s1;
      st_next.step_prev = st_reg.step_s2;
      st_next.dir_s1 = i_travel_sense;
      st_next.dir_s2 = st_reg.dir_s1;
      st_next.dis_s1 = i_output_disable_n;
      st_next.dis_s2 = st_reg.dis_s1;
      st_next.uvlo_s1 = i_uvlo;
      st_next.uvlo_s2 = st_reg.uvlo_s1;
      st_next.lo_s1 = i_step_cfg_lo;
      st_next.lo_s2 = st_reg.lo_s1;
      st_next.hi_s1 = i_step_cfg_hi;
      st_next.hi_s2 = st_reg.hi_s1;
      // position as worked out above
      st_next.idx = idx_new;
      // sign and magnitude by quadrant
      case (idx_new[6:5])
         2'h0: begin
            st_next.wind_a = '{neg: 1'b0, mag: s_c};
            st_next.wind_b = '{neg: 1'b0, mag: s_r};
         end
         2'h1: begin
            st_next.wind_a = '{neg: 1'b1, mag: s_r};
            st_next.wind_b = '{neg: 1'b0, mag: s_c};
         end
         2'h2: begin
            st_next.wind_a = '{neg: 1'b1, mag: s_c};
            st_next.wind_b = '{neg: 1'b1, mag: s_r};
         end
         default: begin
            st_next.wind_a = '{neg: 1'b0, mag: s_r};
            st_next.wind_b = '{neg: 1'b1, mag: s_c};
         end
      endcase
      // disable stops the bridge only; sleep and lockout also hold the indexer home
      st_next.bridge_en = ~st_reg.dis_s2 & ~st_reg.sleep & ~st_reg.uvlo_s2;
      // bus data phase write
      st_next.wr_pend = 1'b0;
      if (st_reg.wr_pend && (st_reg.wr_addr == `MI_ADDR_CTRL)) begin
         st_next.sleep = i_hwdata[`MI_CTRL_SLEEP];
      end
      // bus address phase
      if (addr_ph) begin
         st_next.wr_pend = i_hwrite;
         st_next.wr_addr = i_haddr[3:0];
         st_next.rdata = 32'h0000_0000;
         if (!i_hwrite && (i_haddr[31:4] == 28'h000_0000)) begin
            case (i_haddr[3:0])
               `MI_ADDR_CTRL: begin
                  st_next.rdata[`MI_CTRL_SLEEP] = st_reg.sleep;
               end
               `MI_ADDR_STATUS: begin
                  st_next.rdata[`MI_ST_IDX_LSB +: 7] = st_reg.idx;
                  st_next.rdata[`MI_ST_FMT_LSB +: 3] = fmt;
                  st_next.rdata[`MI_ST_DUAL] = dual;
                  st_next.rdata[`MI_ST_A_LSB +: 8] = st_reg.wind_a;
                  st_next.rdata[`MI_ST_B_LSB +: 8] = st_reg.wind_b;
               end
               default: begin
                  st_next.rdata = 32'h0000_0000;
               end
            endcase
         end
         if (i_haddr[31:4] != 28'h000_0000) begin
            st_next.wr_pend = 1'b0;
         end
      end
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------

   // power-up lands on the home entry
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '0;
         st_reg.idx <= `MI_HOME_IDX;
         st_reg.wind_a.mag <= `MI_HOME_MAG;
         st_reg.wind_b.mag <= `MI_HOME_MAG;
      end else begin
         st_reg <= st_next;
      end
   end

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------

   assign o_hrdata = st_reg.rdata;
   assign o_hreadyout = 1'b1; // never waits
   assign o_hresp = 1'b0; // always okay
   assign o_wind_a = st_reg.wind_a;
   assign o_wind_b = st_reg.wind_b;
   assign o_bridge_en = st_reg.bridge_en;
   assign o_pos_idx = st_reg.idx;

endmodule // mi_indexer
`default_nettype wire

// ==== common/mi_map.svh ====
/*
 constants of the microstep indexer: tri-level codes, table steps,
 home entry and the register map.
 assumes the pin comparators give each tri-level pin as a 2-bit code.
*/
//------------------------------------------------------------
// Summary of operation
// - each valid step edge moves to the next entry valid for the format, direction from travel_sense
// - 1/8, 1/16, 1/32 may advance on both edges when dual-edge selected
// - output_disable_n high stops only the bridge; position keeps tracking
// - hi low: lo low/Z/high gives full, half, quarter; rising only
// - hi Z: lo low 1/8 rising only, lo Z 1/8 both edges
// - hi Z lo high 1/16 rising; hi high lo low 1/16 both edges
// - hi high lo Z 1/32 rising; both high 1/32 both edges
// - each step_cfg pin reads low, high or undriven
// - format may change while moving; next edge goes to next valid entry
// - home is the 45 degree entry, both windings at 71 percent
// - position returns home after power-up, undervoltage exit and sleep exit
// - travel_sense high steps forward in angle, low steps in reverse
// - positive target drives pos terminal above neg terminal
// - signed A/B percent table in 1/32 steps, A 100 B 0 at zero
// - coarser formats use every 2nd, 4th, 8th, 16th entry; full uses 45 family
//------------------------------------------------------------
`ifndef MI_MAP_SVH
`define MI_MAP_SVH
// tri-level pin codes
`define MI_TRI_LOW 2'h0
`define MI_TRI_Z 2'h1
`define MI_TRI_HIGH 2'h2
// index steps per format, full-step offset, home entry and magnitude, quarter span
`define MI_STEP_FULL 7'h20
`define MI_STEP_HALF 7'h10
`define MI_STEP_QTR 7'h08
`define MI_STEP_8TH 7'h04
`define MI_STEP_16TH 7'h02
`define MI_STEP_32ND 7'h01
`define MI_FULL_OFS 7'h10
`define MI_HOME_IDX 7'h10
`define MI_HOME_MAG 7'h47
`define MI_QUARTER 6'h20
// register map
`define MI_ADDR_CTRL 4'h0
`define MI_ADDR_STATUS 4'h4
`define MI_CTRL_SLEEP 0
`define MI_ST_IDX_LSB 0
`define MI_ST_FMT_LSB 8
`define MI_ST_DUAL 11
`define MI_ST_A_LSB 16
`define MI_ST_B_LSB 24
`endif

// ==== common/mi_pkg.sv ====
/*
 types of the microstep indexer.
 assumes mi_map.svh for the numeric constants.
*/
`default_nettype none
package mi_pkg;
   // step formats
   typedef enum logic [2:0] {
      FMT_FULL, FMT_HALF, FMT_QTR, FMT_8TH, FMT_16TH, FMT_32ND
   } mi_fmt_type;
   // one signed winding target
   typedef struct packed {
      logic neg;
      logic [6:0] mag;
   } mi_wind_type;
   // whole module state
   typedef struct packed {
      logic step_s1;
      logic step_s2;
      logic step_prev;
      logic dir_s1;
      logic dir_s2;
      logic dis_s1;
      logic dis_s2;
      logic uvlo_s1;
      logic uvlo_s2;
      logic [1:0] lo_s1;
      logic [1:0] lo_s2;
      logic [1:0] hi_s1;
      logic [1:0] hi_s2;
      logic [6:0] idx;
      mi_wind_type wind_a;
      mi_wind_type wind_b;
      logic bridge_en;
      logic sleep;
      logic wr_pend;
      logic [3:0] wr_addr;
      logic [31:0] rdata;
   } mi_state_type;
endpackage
`default_nettype wire

// ==== verif/mi_step_ctl.sv ====
/*
 motion controller model driving the step/direction pins.
 assumes its tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module mi_step_ctl (
   // clock
   input wire logic i_ref_clk,
   // pins towards the indexer
   output logic o_step,
   output logic o_travel_sense,
   output logic [1:0] o_cfg_lo,
   output logic [1:0] o_cfg_hi,
   output logic o_output_disable_n
);
   // pins at rest at time zero
   initial begin
      o_step = 1'b0;
      o_travel_sense = 1'b1;
      o_cfg_lo = 2'h0;
      o_cfg_hi = 2'h0;
      o_output_disable_n = 1'b0;
   end

   // format code 0..8 is hi*3+lo; pins settle well before any step edge
   task automatic setup(input int fi, input logic fwd, input logic dis);
      o_cfg_hi <= 2'(fi / 3);
      o_cfg_lo <= 2'(fi % 3);
      o_travel_sense <= fwd;
      o_output_disable_n <= dis;
      repeat (4) @(posedge i_ref_clk);
   endtask

   // one whole pulse; each level held gap cycles, 2 at the fastest
   task automatic pulse(input int gap);
      repeat (2) begin
         o_step <= ~o_step;
         repeat (gap) @(posedge i_ref_clk);
      end
   endtask
endmodule // mi_step_ctl

`default_nettype wire

// ==== verif/mi_indexer_props.sv ====
/*
 port assertions of the microstep indexer.
 assumes one clock domain and the async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module mi_indexer_props (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // pins
   input wire logic i_step,
   input wire logic i_travel_sense,
   input wire logic i_output_disable_n,
   input wire logic i_uvlo,
   // outputs
   input wire mi_pkg::mi_wind_type o_wind_a,
   input wire mi_pkg::mi_wind_type o_wind_b,
   input wire logic o_bridge_en,
   input wire logic [6:0] o_pos_idx
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);

   property p_home_rst;
      $rose(i_nrst) |-> o_pos_idx == 7'h10;
   endproperty
   a_home_rst: assert property (p_home_rst) else $error("not home after reset");

   property p_uvlo_home;
      i_uvlo [*4] |-> o_pos_idx == 7'h10;
   endproperty
   a_uvlo_home: assert property (p_uvlo_home) else $error("not home in lockout");

   property p_home_val;
      o_pos_idx == 7'h10 |-> o_wind_a == 8'h47 && o_wind_b == 8'h47;
   endproperty
   a_home_val: assert property (p_home_val) else $error("home currents wrong");

   property p_zero_val;
      o_pos_idx == 7'h00 |-> o_wind_a == 8'h64 && o_wind_b.mag == 7'h00;
   endproperty
   a_zero_val: assert property (p_zero_val) else $error("zero angle wrong");

   property p_neg_a;
      o_pos_idx > 7'h20 && o_pos_idx < 7'h60 |-> o_wind_a.neg;
   endproperty
   a_neg_a: assert property (p_neg_a) else $error("winding a sign wrong");

   property p_dis_off;
      i_output_disable_n [*4] |-> !o_bridge_en;
   endproperty
   a_dis_off: assert property (p_dis_off) else $error("bridge on while disabled");

   property p_cause;
      o_pos_idx != $past(o_pos_idx) && o_pos_idx != 7'h10 |->
         $past(i_step, 3) != $past(i_step, 4);
   endproperty
   a_cause: assert property (p_cause) else $error("move without step edge");

   property p_dir;
      o_pos_idx != $past(o_pos_idx) && o_pos_idx != 7'h10 |->
         ($past(i_travel_sense, 3) ? 7'(o_pos_idx - $past(o_pos_idx)) <= 7'h20
            : 7'(o_pos_idx - $past(o_pos_idx)) >= 7'h60);
   endproperty
   a_dir: assert property (p_dir) else $error("move in wrong sense");

   property p_wind_follow;
      $changed(o_wind_a) || $changed(o_wind_b) |-> $changed(o_pos_idx);
   endproperty
   a_wind_follow: assert property (p_wind_follow) else $error("targets moved alone");
endmodule // mi_indexer_props

bind mi_indexer mi_indexer_props u_props (
   .i_ref_clk(i_ref_clk),
   .i_nrst(i_nrst),
   .i_step(i_step),
   .i_travel_sense(i_travel_sense),
   .i_output_disable_n(i_output_disable_n),
   .i_uvlo(i_uvlo),
   .o_wind_a(o_wind_a),
   .o_wind_b(o_wind_b),
   .o_bridge_en(o_bridge_en),
   .o_pos_idx(o_pos_idx)
);

`default_nettype wire

// ==== verif/mi_indexer_tb.sv ====
/*
 self-checking bench of the microstep indexer.
 assumes mi_step_ctl drives the pins and the bench is the bus master.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mi_map.svh"
`define CHK(a, b) \
   begin \
      check_count++; \
      if ((a) !== (b)) begin \
         error_cnt++; \
         $display("ERROR %0t: got %h want %h", $time, a, b); \
      end \
   end

module mi_indexer_tb;
   logic clk, nrst, step, dir, dis, uvlo, hsel, hwrite, hready, hresp, bren;
   logic [1:0] lo, hi, htrans;
   logic [2:0] hsize;
   logic [3:0] ef;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [6:0] pidx, exp_idx;
   mi_pkg::mi_wind_type wa, wb;
   int error_cnt, check_count;
   int stp[9] = '{32, 16, 8, 4, 4, 2, 2, 1, 1};
   int fmt[9] = '{0, 1, 2, 3, 3, 4, 4, 5, 5};
   // percent of full scale at each 1/32 step of a quarter turn
   int pct[33] = '{0, 5, 10, 15, 20, 24, 29, 34, 38, 43, 47, 51, 56, 60, 63, 67, 71, 74,
      77, 80, 83, 86, 88, 90, 92, 94, 96, 97, 98, 99, 100, 100, 100};

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   mi_indexer u_dut (
      .i_ref_clk(clk), .i_nrst(nrst), .i_step(step), .i_travel_sense(dir),
      .i_step_cfg_lo(lo), .i_step_cfg_hi(hi), .i_output_disable_n(dis),
      .i_uvlo(uvlo), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .o_wind_a(wa), .o_wind_b(wb), .o_bridge_en(bren), .o_pos_idx(pidx)
   );
   mi_step_ctl u_ctl (
      .i_ref_clk(clk), .o_step(step), .o_travel_sense(dir), .o_cfg_lo(lo),
      .o_cfg_hi(hi), .o_output_disable_n(dis)
   );

   // formats that count both step edges
   function automatic logic dual(input int fi);
      return fi == 4 || fi == 6 || fi == 8;
   endfunction

   // next aligned entry of the format; full step sits on the 45 degree family
   function automatic logic [6:0] nxt(input logic [6:0] p, input int s, input logic f);
      int o, r;
      o = (s == 32) ? 16 : 0;
      r = (p - o + 128) % 128;
      r = f ? (r / s + 1) * s : ((r + s - 1) / s - 1) * s;
      return 7'((r + o + 128) % 128);
   endfunction

   // signed target of the sine winding at entry x; the cosine one is x plus a quarter
   function automatic logic [7:0] wexp(input logic [6:0] x);
      int r;
      r = x[5] ? 32 - x[4:0] : x[4:0];
      return {x[6], 7'(pct[r])};
   endfunction

   // one single-word transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // n pulses, then compare the position with the tracked one
   task automatic mv(input int n, input int fi, input logic f, input int gap);
      repeat (n) begin
         u_ctl.pulse(gap);
         repeat (dual(fi) ? 2 : 1) exp_idx = nxt(exp_idx, stp[fi], f);
      end
      repeat (4) @(posedge clk);
      `CHK(pidx, exp_idx)
      `CHK(wa, wexp(7'(exp_idx + 7'h20)))
      `CHK(wb, wexp(exp_idx))
   endtask

   // verdict and end of run
   task automatic test_done();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      test_done();
   end

   // main sequence
   initial begin
      nrst = 1'b0;
      uvlo = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      error_cnt = 0;
      check_count = 0;
      exp_idx = 7'h10;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      `CHK(pidx, 7'h10)
      `CHK(wa, 8'h47)
      // every format code, sense alternating with the code's low bit, step levels held 4, 3 and 2 cycles in turn
      for (int i = 8; i >= 0; i--) begin
         u_ctl.setup(i, i[0], 1'b0);
         mv(2, i, i[0], 2 + i % 3);
         bus(1'b0, {28'h0, `MI_ADDR_STATUS}, 32'h0);
         ef = {dual(i), 3'(fmt[i])};
         `CHK(rd[6:0], exp_idx)
         `CHK(rd[11:8], ef)
         `CHK(rd[23:16], wexp(7'(exp_idx + 7'h20)))
         `CHK(rd[31:24], wexp(exp_idx))
      end
      // bridge off, position still tracks
      u_ctl.setup(7, 1'b1, 1'b1);
      `CHK(bren, 1'b0)
      mv(3, 7, 1'b1, 3);
      u_ctl.setup(7, 1'b1, 1'b0);
      `CHK(bren, 1'b1)
      // sleep holds home and ignores steps
      bus(1'b1, {28'h0, `MI_ADDR_CTRL}, 32'h1);
      bus(1'b0, {28'h0, `MI_ADDR_CTRL}, 32'h0);
      `CHK(rd[0], 1'b1)
      `CHK(hresp, 1'b0)
      u_ctl.pulse(3);
      repeat (4) @(posedge clk);
      `CHK(pidx, 7'h10)
      bus(1'b1, {28'h0, `MI_ADDR_CTRL}, 32'h0);
      bus(1'b0, 32'h10, 32'h0);
      `CHK(rd, 32'h0)
      exp_idx = 7'h10;
      // undervoltage sends the position home
      mv(1, 7, 1'b1, 2);
      uvlo <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(pidx, 7'h10)
      uvlo <= 1'b0;
      repeat (4) @(posedge clk);
      exp_idx = 7'h10;
      // reverse to zero and across the wrap, then full steps
      u_ctl.setup(7, 1'b0, 1'b0);
      mv(16, 7, 1'b0, 2);
      `CHK(wa, 8'h64)
      `CHK(wb.mag, 7'h00)
      mv(1, 7, 1'b0, 2);
      u_ctl.setup(0, 1'b1, 1'b0);
      mv(2, 0, 1'b1, 2);
      `CHK(wa, 8'hC7)
      `CHK(wb, 8'h47)
      // reset in mid-run brings the position back home from off-home
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      `CHK(pidx, 7'h10)
      `CHK(wa, 8'h47)
      test_done();
   end
endmodule // mi_indexer_tb

`default_nettype wire
